// ---- hdl/hbc_connect.sv ----
// Top: connection controller and wired-AND buffer for a two-wire bus
module hbc_connect
    import hbc_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES   // Bus idle interval in cycles
)
(
    input  wire logic clock,                 // System clock
    input  wire logic rst_n,                 // Async reset, active low
    input  wire logic supply_ok,             // Supply above lockout level
    input  wire logic sense_n,               // Connection sense, high isolates
    input  wire logic backplane_data_i,      // Backplane data pin level
    output logic      backplane_data_o,      // Backplane data drive value (low)
    output logic      backplane_data_oe,     // Backplane data pull-down enable
    input  wire logic backplane_clock_i,     // Backplane clock pin level
    output logic      backplane_clock_o,     // Backplane clock drive value (low)
    output logic      backplane_clock_oe,    // Backplane clock pull-down enable
    input  wire logic card_data_i,           // Card data pin level
    output logic      card_data_o,           // Card data drive value (low)
    output logic      card_data_oe,          // Card data pull-down enable
    input  wire logic card_clock_i,          // Card clock pin level
    output logic      card_clock_o,          // Card clock drive value (low)
    output logic      card_clock_oe,         // Card clock pull-down enable
    output logic      precharge_en,          // Weak precharge bias on all lines
    output logic      ready_o,               // Ready drive value (low)
    output logic      ready_oe               // Ready pull-down enable
);
    // ==========================================
    // Input sampling
    hbc_sync_if sl ();                       // Synchronised levels

    hbc_sync u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .raw   ({sense_n, card_clock_i, card_data_i, backplane_clock_i, backplane_data_i}),
        .sync  (sl.src)
    );

    // Supply flag passes two flops kept in the controller state

    // ==========================================
    // Controller state
    typedef struct packed {
        hbc_state_e              state;      // Controller state
        logic                    sup_meta;   // Supply flag, first stage
        logic                    sup;        // Supply flag, second stage
        logic                    bpd_d;      // Last backplane data level
        logic [IDLE_CNT_W-1:0]   idle_cnt;   // Idle high counter
        logic                    drv_bpd;    // Pull backplane data low
        logic                    drv_bpc;    // Pull backplane clock low
        logic                    drv_cdd;    // Pull card data low
        logic                    drv_cdc;    // Pull card clock low
        logic [SYNC_STAGES-1:0]  hist_bpd;   // Recent backplane data pulls
        logic [SYNC_STAGES-1:0]  hist_bpc;   // Recent backplane clock pulls
        logic [SYNC_STAGES-1:0]  hist_cdd;   // Recent card data pulls
        logic [SYNC_STAGES-1:0]  hist_cdc;   // Recent card clock pulls
    } hbc_ctl_s;

    hbc_ctl_s c_r;
    hbc_ctl_s c_nxt;

    logic stop_seen;                         // Stop condition this cycle
    logic idle_seen;                         // Idle interval reached
    logic bp_low_d;                          // Backplane data low from outside
    logic cd_low_d;                          // Card data low from outside
    logic bp_low_c;                          // Backplane clock low from outside
    logic cd_low_c;                          // Card clock low from outside

    // Event detection on backplane pair, outside lows on both pairs
    always_comb
    begin
        stop_seen = sl.bp_data && !c_r.bpd_d && sl.bp_clock;
        idle_seen = (c_r.idle_cnt >= IDLE_LIMIT[IDLE_CNT_W-1:0]);
        // A low seen while our pull-down or its echo through the
        // synchroniser may be on that line is ours; otherwise a participant's
        bp_low_d  = !sl.bp_data  && !(c_r.drv_bpd || (|c_r.hist_bpd));
        cd_low_d  = !sl.cd_data  && !(c_r.drv_cdd || (|c_r.hist_cdd));
        bp_low_c  = !sl.bp_clock && !(c_r.drv_bpc || (|c_r.hist_bpc));
        cd_low_c  = !sl.cd_clock && !(c_r.drv_cdc || (|c_r.hist_cdc));
    end

    // Next state
    always_comb
    begin
        c_nxt       = c_r;
        c_nxt.bpd_d = sl.bp_data;
        // Supply flag through two flops
        c_nxt.sup_meta = supply_ok;
        c_nxt.sup      = c_r.sup_meta;
        // Pull-down history as deep as the input synchroniser
        c_nxt.hist_bpd = {c_r.hist_bpd[SYNC_STAGES-2:0], c_r.drv_bpd};
        c_nxt.hist_bpc = {c_r.hist_bpc[SYNC_STAGES-2:0], c_r.drv_bpc};
        c_nxt.hist_cdd = {c_r.hist_cdd[SYNC_STAGES-2:0], c_r.drv_cdd};
        c_nxt.hist_cdc = {c_r.hist_cdc[SYNC_STAGES-2:0], c_r.drv_cdc};
        // Idle counter counts while both backplane lines high
        if (sl.bp_data && sl.bp_clock)
        begin
            if (!idle_seen)
            begin
                c_nxt.idle_cnt = c_r.idle_cnt + IDLE_ONE;
            end
        end
        else
        begin
            c_nxt.idle_cnt = IDLE_ZERO;
        end
        unique case (c_r.state)
            HBC_LOCKOUT:
            begin
                // Line activity ignored until supply good
                if (c_r.sup)
                begin
                    c_nxt.state    = HBC_WAIT;
                    c_nxt.idle_cnt = IDLE_ZERO;
                end
            end
            HBC_WAIT:
            begin
                if (sl.sense)
                begin
                    c_nxt.idle_cnt = IDLE_ZERO;
                end
                else if (stop_seen || idle_seen)
                begin
                    c_nxt.state = HBC_CHECK;
                end
            end
            HBC_CHECK:
            begin
                if (sl.sense)
                begin
                    c_nxt.state = HBC_WAIT;
                end
                else if (sl.cd_data && sl.cd_clock)
                begin
                    c_nxt.state = HBC_LINK;
                end
            end
            HBC_LINK:
            begin
                if (sl.sense)
                begin
                    c_nxt.state    = HBC_WAIT;
                    c_nxt.idle_cnt = IDLE_ZERO;
                end
            end
        endcase
        if (!c_r.sup)
        begin
            c_nxt.state = HBC_LOCKOUT;
        end
        // Wired-AND: mirror a participant's low to the other side
        if (c_nxt.state == HBC_LINK && c_r.state == HBC_LINK)
        begin
            c_nxt.drv_cdd = bp_low_d;
            c_nxt.drv_bpd = cd_low_d;
            c_nxt.drv_cdc = bp_low_c;
            c_nxt.drv_bpc = cd_low_c;
        end
        else
        begin
            c_nxt.drv_bpd = 1'b0;
            c_nxt.drv_bpc = 1'b0;
            c_nxt.drv_cdd = 1'b0;
            c_nxt.drv_cdc = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c_r <= '{state: HBC_LOCKOUT, sup_meta: 1'b0, sup: 1'b0, bpd_d: 1'b1,
                     idle_cnt: IDLE_ZERO,
                     drv_bpd: 1'b0, drv_bpc: 1'b0, drv_cdd: 1'b0, drv_cdc: 1'b0,
                     hist_bpd: '0, hist_bpc: '0, hist_cdd: '0, hist_cdc: '0};
        end
        else
        begin
            c_r <= c_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign backplane_data_o   = 1'b0;
    assign backplane_clock_o  = 1'b0;
    assign card_data_o        = 1'b0;
    assign card_clock_o       = 1'b0;
    assign ready_o            = 1'b0;
    assign backplane_data_oe  = c_r.drv_bpd;
    assign backplane_clock_oe = c_r.drv_bpc;
    assign card_data_oe       = c_r.drv_cdd;
    assign card_clock_oe      = c_r.drv_cdc;
    assign precharge_en       = (c_r.state == HBC_LOCKOUT);
    assign ready_oe           = (c_r.state != HBC_LINK);

    // ==========================================
    // Checks
    chk_lockout_precharge: assert property (@(posedge clock) disable iff (!rst_n)
        !c_r.sup |=> precharge_en && ready_oe)
        else $error("precharge or ready wrong in lockout");
    chk_sense_isolate: assert property (@(posedge clock) disable iff (!rst_n)
        sl.sense |=> ##1 (ready_oe && !card_data_oe && !backplane_data_oe &&
            !card_clock_oe && !backplane_clock_oe))
        else $error("sense high did not isolate");
    chk_ready_link: assert property (@(posedge clock) disable iff (!rst_n)
        !ready_oe |-> c_r.state == HBC_LINK)
        else $error("ready released while not linked");
    chk_link_from_check: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(c_r.state == HBC_LINK) |-> $past(sl.cd_data && sl.cd_clock))
        else $error("linked without card lines high");
    chk_check_cause: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(c_r.state == HBC_CHECK) |-> $past(stop_seen || idle_seen))
        else $error("left wait without stop or idle");
    chk_data_mirror: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.state == HBC_LINK && bp_low_d && c_r.sup && !sl.sense) ##1
        (c_r.state == HBC_LINK) |-> card_data_oe)
        else $error("backplane data low not mirrored");
    chk_clock_release: assert property (@(posedge clock) disable iff (!rst_n)
        (!cd_low_c) |=> !backplane_clock_oe)
        else $error("clock held low after release");
    chk_echo_block: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(card_data_oe) |=> !backplane_data_oe ##1 !backplane_data_oe)
        else $error("own data release echoed back");
    chk_drop_wait: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.state == HBC_LINK && sl.sense && c_r.sup) |=> c_r.state == HBC_WAIT)
        else $error("link not dropped on sense");
    chk_lock_ignore: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.state == HBC_LOCKOUT && !c_r.sup) |=> c_r.state == HBC_LOCKOUT)
        else $error("lockout left without supply");
    chk_sense_wait: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.state == HBC_WAIT && sl.sense) |=> c_r.state != HBC_CHECK)
        else $error("advanced while sense high");
    chk_stop_detect: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.state == HBC_WAIT && c_r.sup && !sl.sense && sl.bp_clock && sl.bp_data &&
         !c_r.bpd_d) |=> c_r.state == HBC_CHECK)
        else $error("stop not acted on");
    chk_ready_low: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.state != HBC_LINK) |-> ready_oe)
        else $error("ready not pulled low");
    chk_join: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.state == HBC_CHECK && !sl.sense && c_r.sup && sl.cd_data && sl.cd_clock)
        |=> c_r.state == HBC_LINK)
        else $error("did not join when ready");
endmodule // hbc_connect

// ---- hdl/hbc_pkg.sv ----
// Package: constants and types for the bus connect controller
package hbc_pkg;
    // ==========================================
    // Timing
    localparam int CLOCK_HZ        = 50_000_000;              // System clock rate
    localparam int IDLE_TIME_US    = 95;                      // Bus idle interval
    localparam int IDLE_CYCLES     = (IDLE_TIME_US * (CLOCK_HZ / 1_000_000)); // Idle count
    localparam int SYNC_STAGES     = 2;                       // Synchroniser depth
    localparam int IDLE_CNT_W      = 16;                      // Idle counter width

    // ==========================================
    // Controller states, one-hot
    typedef enum logic [3:0] {
        HBC_LOCKOUT = 4'b0001,   // Supply lockout, precharge on
        HBC_WAIT    = 4'b0010,   // Wait for stop or idle on backplane
        HBC_CHECK   = 4'b0100,   // Wait for both card lines high
        HBC_LINK    = 4'b1000    // Sides joined
    } hbc_state_e;

    localparam logic [IDLE_CNT_W-1:0] IDLE_ZERO = 16'h0000;   // Counter clear value
    localparam logic [IDLE_CNT_W-1:0] IDLE_ONE  = 16'h0001;   // Counter step
endpackage : hbc_pkg

// ---- hdl/hbc_sync_if.sv ----
// Interface: synchronised line levels passed from the sampler to the controller
interface hbc_sync_if;
    logic bp_data;    // Backplane data level
    logic bp_clock;   // Backplane clock level
    logic cd_data;    // Card data level
    logic cd_clock;   // Card clock level
    logic sense;      // Connection sense level, high isolates
    modport src (output bp_data, bp_clock, cd_data, cd_clock, sense);
    modport dst (input  bp_data, bp_clock, cd_data, cd_clock, sense);
endinterface : hbc_sync_if

// ---- hdl/hbc_sync.sv ----
// Module: two-flop synchronisers for the five outside inputs
module hbc_sync
    import hbc_pkg::*;
(
    input  wire logic        clock,     // System clock
    input  wire logic        rst_n,     // Async reset, active low
    input  wire logic [4:0]  raw,       // Raw pin levels
    hbc_sync_if.src          sync       // Synchronised levels
);
    // ==========================================
    // State
    typedef struct packed {
        logic [4:0] meta;   // First stage, read only by second
        logic [4:0] stab;   // Second stage
    } hbc_sync_s;

    hbc_sync_s st_r;
    hbc_sync_s st_nxt;

    // Next state
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.meta = raw;
        st_nxt.stab = st_r.meta;
    end

    // Registers; lines idle high, sense isolates at reset
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '{meta: '1, stab: '1};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sync.bp_data  = st_r.stab[0];
    assign sync.bp_clock = st_r.stab[1];
    assign sync.cd_data  = st_r.stab[2];
    assign sync.cd_clock = st_r.stab[3];
    assign sync.sense    = st_r.stab[4];
endmodule // hbc_sync

// ---- verif/hbc_bus_model.sv ----
// Partner model: pulled-up open-drain wires of the backplane and card pairs
module hbc_bus_model
(
    input  wire logic bp_data_pd,    // Backplane participant pulls data low
    input  wire logic bp_clock_pd,   // Backplane participant pulls clock low
    input  wire logic cd_data_pd,    // Card participant pulls data low
    input  wire logic cd_clock_pd,   // Card participant pulls clock low
    input  wire logic bp_data_oe,    // Device pulls backplane data low
    input  wire logic bp_clock_oe,   // Device pulls backplane clock low
    input  wire logic cd_data_oe,    // Device pulls card data low
    input  wire logic cd_clock_oe,   // Device pulls card clock low
    output logic      bp_data_w,     // Resolved backplane data
    output logic      bp_clock_w,    // Resolved backplane clock
    output logic      cd_data_w,     // Resolved card data
    output logic      cd_clock_w     // Resolved card clock
);
    // ==========================================
    // Wired-AND with pull-up: a released line rises to high
    assign bp_data_w  = ~(bp_data_pd | bp_data_oe);
    assign bp_clock_w = ~(bp_clock_pd | bp_clock_oe);
    assign cd_data_w  = ~(cd_data_pd | cd_data_oe);
    assign cd_clock_w = ~(cd_clock_pd | cd_clock_oe);
endmodule // hbc_bus_model

// ---- verif/hbc_connect_tb_top.sv ----
// Testbench: self-checking scenarios for the bus connect controller
module hbc_connect_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst_n, supply_ok, sense_n;          // Clock, reset, controls
    logic bp_d_pd, bp_c_pd, cd_d_pd, cd_c_pd;        // Bench participant pulls
    logic bp_d_oe, bp_c_oe, cd_d_oe, cd_c_oe;        // Device pulls
    logic bp_d_w, bp_c_w, cd_d_w, cd_c_w;            // Resolved wires
    logic precharge_en, ready_oe;                    // Status outputs
    logic bp_d_o, bp_c_o, cd_d_o, cd_c_o, ready_o;   // Drive values, always low
    int   fails = 0;                                 // Mismatch count
    int   samples_checked = 0;                       // Comparison count
    // ==========================================
    // Design and partner
    hbc_connect #(.IDLE_LIMIT(20)) u_hbc_connect (.clock(clock), .rst_n(rst_n),
        .supply_ok(supply_ok), .sense_n(sense_n),
        .backplane_data_i(bp_d_w), .backplane_data_o(bp_d_o), .backplane_data_oe(bp_d_oe),
        .backplane_clock_i(bp_c_w), .backplane_clock_o(bp_c_o), .backplane_clock_oe(bp_c_oe),
        .card_data_i(cd_d_w), .card_data_o(cd_d_o), .card_data_oe(cd_d_oe),
        .card_clock_i(cd_c_w), .card_clock_o(cd_c_o), .card_clock_oe(cd_c_oe),
        .precharge_en(precharge_en), .ready_o(ready_o), .ready_oe(ready_oe));
    hbc_bus_model u_hbc_bus_model (.bp_data_pd(bp_d_pd), .bp_clock_pd(bp_c_pd),
        .cd_data_pd(cd_d_pd), .cd_clock_pd(cd_c_pd), .bp_data_oe(bp_d_oe),
        .bp_clock_oe(bp_c_oe), .cd_data_oe(cd_d_oe), .cd_clock_oe(cd_c_oe),
        .bp_data_w(bp_d_w), .bp_clock_w(bp_c_w), .cd_data_w(cd_d_w), .cd_clock_w(cd_c_w));
    // ==========================================
    // Clock, 20 ns period
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Advance n cycles, land just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    // Compare one bit
    task automatic check_bit(input logic got, input logic exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    // Pick a watched output
    function automatic logic pick(input int sel);
        case (sel)
            0:       return ready_oe;
            1:       return bp_d_oe;
            2:       return cd_c_oe;
            3:       return cd_d_oe;
            default: return bp_c_oe;
        endcase
    endfunction
    // Bounded wait for a watched output to reach a value
    task automatic wait_for(input int sel, input logic val, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            step(1);
            if (pick(sel) === val) return;
        end
        check_bit(pick(sel), val, "output did not change in time");
    endtask
    // ==========================================
    // Scenarios
    task automatic t_lockout();
        for (int i = 0; i < 4; i++)
        begin
            bp_c_pd = ~bp_c_pd;
            step(4);
            bp_d_pd = ~bp_d_pd;
            step(4);
        end
        check_bit(ready_oe, 1'b1, "ready released in lockout");
        check_bit(precharge_en, 1'b1, "precharge off in lockout");
        check_bit(bp_d_oe | bp_c_oe | cd_d_oe | cd_c_oe, 1'b0, "joined in lockout");
        check_bit(bp_d_o | bp_c_o | cd_d_o | cd_c_o | ready_o, 1'b0, "drive high");
    endtask
    task automatic t_start();
        supply_ok = 1'b1;
        bp_d_pd = 1'b1;
        step(6);
        check_bit(precharge_en, 1'b0, "precharge still on");
        for (int i = 0; i < 6; i++)
        begin
            bp_c_pd = ~bp_c_pd;
            step(4);
        end
        check_bit(ready_oe, 1'b1, "joined mid transfer");
        bp_c_pd = 1'b0;
        step(4);
        bp_d_pd = 1'b0;
        wait_for(0, 1'b0, 8);
        check_bit(cd_d_w & cd_c_w, 1'b1, "card lines not high");
    endtask
    task automatic t_mirror();
        // Data pair, card side first, then overlap with the backplane
        cd_d_pd = 1'b1;
        wait_for(1, 1'b1, 8);
        check_bit(bp_d_w, 1'b0, "backplane data not low");
        bp_d_pd = 1'b1;
        step(2);
        cd_d_pd = 1'b0;
        step(10);
        check_bit(cd_d_oe, 1'b1, "card data rose early");
        bp_d_pd = 1'b0;
        wait_for(3, 1'b0, 8);
        step(6);
        check_bit(bp_d_oe | cd_d_oe, 1'b0, "data pull echoed back");
        // Clock pair from the backplane side
        bp_c_pd = 1'b1;
        wait_for(2, 1'b1, 8);
        check_bit(cd_c_w, 1'b0, "card clock not low");
        bp_c_pd = 1'b0;
        wait_for(2, 1'b0, 8);
        // Clock pair from the card side
        cd_c_pd = 1'b1;
        wait_for(4, 1'b1, 8);
        check_bit(bp_c_w, 1'b0, "backplane clock not low");
        cd_c_pd = 1'b0;
        wait_for(4, 1'b0, 8);
        check_bit(bp_d_w & bp_c_w & cd_d_w & cd_c_w, 1'b1, "line stuck");
    endtask
    task automatic t_sense();
        sense_n = 1'b1;
        wait_for(0, 1'b1, 4);
        cd_d_pd = 1'b1;
        step(8);
        check_bit(bp_d_oe, 1'b0, "data passed while isolated");
        step(40);
        check_bit(ready_oe, 1'b1, "ready released while sensed");
        // Idle is timed from sense low, so no join before it runs out
        sense_n = 1'b0;
        step(10);
        check_bit(ready_oe, 1'b1, "joined before idle time");
        step(30);
        check_bit(ready_oe, 1'b1, "joined with card data low");
        cd_d_pd = 1'b0;
        wait_for(0, 1'b0, 8);
    endtask
    task automatic t_supply();
        // Supply loss while linked, card data pulled during the drop
        supply_ok = 1'b0;
        cd_d_pd = 1'b1;
        wait_for(0, 1'b1, 6);
        step(4);
        check_bit(precharge_en, 1'b1, "precharge off after supply loss");
        check_bit(bp_d_oe, 1'b0, "data passed after supply loss");
        cd_d_pd = 1'b0;
        step(1);
    endtask
    // ==========================================
    // Verdict and end of run
    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial
    begin
        #200us;
        fails++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        give_verdict();
    end
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        supply_ok = 1'b0;
        sense_n = 1'b0;
        {bp_d_pd, bp_c_pd, cd_d_pd, cd_c_pd} = 4'h0;
        repeat (5) @(posedge clock);
        #2;
        rst_n = 1'b1;
        t_lockout();
        bp_d_pd = 1'b0;
        bp_c_pd = 1'b0;
        t_start();
        t_mirror();
        t_sense();
        t_supply();
        give_verdict();
    end
endmodule // hbc_connect_tb_top
